// File: common/dbg_access_pkg.sv
package dbg_access_pkg;
    // register indices on the access-layer register port
    localparam logic [3:0] OFS_REVISION = 4'h0;
    localparam logic [3:0] OFS_ERROR = 4'h1;
    localparam logic [3:0] OFS_CTRL_A = 4'h2;
    localparam logic [3:0] OFS_CTRL_B = 4'h3;
    localparam logic [3:0] OFS_KEY_STATUS = 4'h7;
    localparam logic [3:0] OFS_RESET_REQ = 4'h8;
    localparam logic [3:0] OFS_CLK_SEL = 4'h9;
    localparam logic [3:0] OFS_SYS_CTRL = 4'hA;
    localparam logic [3:0] OFS_SYS_STATE = 4'hB;
    localparam logic [3:0] OFS_BOOT_CHECK = 4'hC;
    // reset values
    localparam logic [3:0] REV_RESET = 4'h4;
    localparam logic [1:0] CLK_SEL_RESET = 2'h3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // field positions
    localparam int KS_ROW = 5;
    localparam int KS_PROG = 4;
    localparam int KS_ERASE = 3;
    localparam int SC_HOLD = 0;
    localparam int SC_FINISH = 1;
    localparam int SS_RESET = 5;
    localparam int SS_SLEEP = 4;
    localparam int SS_PROG = 3;
    localparam int SS_ROW_READY = 2;
    localparam int SS_LOCK = 0;
    localparam int CB_DISABLE = 2;
    // codes
    localparam logic [7:0] RESET_CODE = 8'h59;
    localparam logic [7:0] RUN_CODE = 8'h00;
    localparam logic [2:0] ERR_BUS = 3'h6;
    localparam logic [63:0] KEY_ERASE = 64'h4E564D4572617365;
    localparam logic [63:0] KEY_PROG = 64'h4E564D50726F6720;
    localparam logic [63:0] KEY_ROW = 64'h4E564D5573267465;
    localparam logic [2:0] KEY_LAST_BYTE = 3'h7;
    localparam int ROW_BYTES = 32;
    localparam logic [5:0] COPY_END = 6'h21;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rsp_t;

    typedef struct packed {
        logic valid;
        logic [4:0] addr;
        logic [7:0] data;
    } row_wr_t;

    typedef struct packed {
        logic erase;
        logic prog;
        logic row;
    } key_match_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ERASE_ARMED, ST_ERASING, ST_PROG_ARMED, ST_PROGRAMMING,
        ST_ROW_ARMED, ST_ROW_READY, ST_ROW_COPY, ST_ROW_DONE
    } seq_state_t;
endpackage

// File: core/key_matcher.sv
`timescale 1ns/1ps
`default_nettype none
module key_matcher import dbg_access_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    // key bytes, least significant first
    input wire logic key_valid,
    input wire logic [7:0] key_byte,
    // one-cycle match pulses
    output key_match_t match
);
    logic [63:0] shift, next_shift;
    logic [2:0] count, next_count;
    key_match_t next_match;

    always_comb begin
        next_shift = shift;
        next_count = count;
        next_match = '0;
        if (clear) begin
            next_count = 3'h0;
        end else if (key_valid) begin
            next_shift = {key_byte, shift[63:8]};
            next_count = count + 3'h1;
            // only a full eight-byte frame is compared
            if (count == KEY_LAST_BYTE) begin
                next_match.erase = (next_shift == KEY_ERASE); // R23
                next_match.prog = (next_shift == KEY_PROG);
                next_match.row = (next_shift == KEY_ROW);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            shift <= '0;
            count <= 3'h0;
            match <= '0;
        end else begin
            shift <= next_shift;
            count <= next_count;
            match <= next_match;
        end
    end
endmodule
`default_nettype wire

// File: core/row_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module row_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // registered read port
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// File: core/debug_access_key_sequencer.sv
// Summary of operation
// R1: erase complete only when lock flag reads 0
// R2: successful erase clears lock, opens bus
// R3: locked: refuse system bus, registers only
// R4: brownout detector forced on during erase
// R5: code writes reset, zero write releases it
// R6: programmer: key, reset cycle, poll flag
// R7: programmer: reset cycle ends programming
// R8: programmer: row key, reset, poll ready
// R9: row mode: only first 32 bytes written
// R10: done bit copies; ready clears after copy
// R11: programmer writes row key bit, resets
// R12: row mode returns no memory contents
// R13: programmer may read key status
// R14: sync rising edges produce unmaskable event
// R15: block consumes no routed events
// R16: link side keeps working in sleep
// R17: no bus access while system clock stopped
// R18: hold bit keeps system clock in sleep
// R19: hold bit is 1 when block enabled
// R20: read-only flag shows system asleep
// R21: 0x59 resets, 0x00 releases, block untouched
// R22: program key clears when programming starts
// R23: 64-bit keys, LSB first, exact match
`timescale 1ns/1ps
`default_nettype none
module debug_access_key_sequencer import dbg_access_pkg::*; #(
    parameter logic [3:0] REVISION = REV_RESET
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // access-layer register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // key bytes and link status
    input wire logic key_valid,
    input wire logic [7:0] key_byte,
    input wire logic phy_err_valid,
    input wire logic [2:0] phy_err_code,
    input wire logic sync_pin,
    // memory access from the link
    input wire bus_req_t link_req,
    output rsp_t link_rsp,
    // system side
    output bus_req_t sys_req,
    input wire rsp_t sys_rsp,
    input wire logic sys_clock_on,
    input wire logic sys_sleeping,
    input wire logic lock_fuse,
    input wire logic erase_done,
    input wire logic [2:0] boot_crc,
    output logic system_reset_active,
    output logic erase_start,
    output logic brownout_force,
    output logic system_clock_hold,
    output row_wr_t row_out,
    output logic sync_event
);
    seq_state_t state, next_state;
    logic [2:0] err, next_err;
    logic [7:0] ctrl_a, next_ctrl_a, ctrl_b, next_ctrl_b;
    logic [7:0] reset_req, next_reset_req;
    logic [1:0] clk_sel, next_clk_sel;
    logic hold, next_hold;
    logic lock_state_flag, next_lock;
    logic lock_loaded;
    logic erase_key_flag, next_erase_key, programming_key_flag, next_prog_key;
    logic row_write_key_flag, next_row_key;
    logic [5:0] idx, next_idx;
    logic next_sys_reset, next_erase_start, next_bod, next_hold_out;
    logic [7:0] next_rdata;
    bus_req_t next_sys_req;
    rsp_t next_link_rsp;
    row_wr_t next_row_out;
    logic sync_q1, sync_q2, sync_q3;
    logic enabled, row_mode, row_program_ready, buf_we;
    logic [7:0] buf_rdata;
    key_match_t match;

    assign enabled = !ctrl_b[CB_DISABLE];
    assign row_mode = (state == ST_ROW_READY) || (state == ST_ROW_COPY)
        || (state == ST_ROW_DONE) || (state == ST_ROW_ARMED);
    assign row_program_ready = (state == ST_ROW_READY) || (state == ST_ROW_COPY); // R10
    assign buf_we = enabled && (state == ST_ROW_READY) && link_req.valid && link_req.write
        && (link_req.addr < 16'(ROW_BYTES)); // R9

    key_matcher u_keys (
        .clk(clk),
        .reset(reset),
        .clear(!enabled),
        .key_valid(key_valid),
        .key_byte(key_byte),
        .match(match)
    );

    row_buffer #(.WIDTH(8), .DEPTH(ROW_BYTES), .AW(5)) u_row (
        .clk(clk),
        .wr_en(buf_we),
        .wr_addr(link_req.addr[4:0]),
        .wr_data(link_req.wdata),
        .rd_addr(idx[4:0]),
        .rd_data(buf_rdata)
    );

    always_comb begin
        next_state = state;
        next_err = err;
        next_ctrl_a = ctrl_a;
        next_ctrl_b = ctrl_b;
        next_reset_req = reset_req;
        next_clk_sel = clk_sel;
        next_hold = hold;
        next_lock = lock_loaded ? lock_state_flag : lock_fuse;
        next_erase_key = erase_key_flag;
        next_prog_key = programming_key_flag;
        next_row_key = row_write_key_flag;
        next_idx = idx;
        next_sys_reset = system_reset_active;
        next_erase_start = 1'b0;
        next_sys_req = '0;
        next_link_rsp = '0;
        next_row_out = '0;
        next_rdata = reg_rdata;
        // register reads; the error field clears on read
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_REVISION: next_rdata = {REVISION, 4'h0};
                OFS_ERROR: next_rdata = {5'h00, err};
                OFS_CTRL_A: next_rdata = ctrl_a;
                OFS_CTRL_B: next_rdata = ctrl_b;
                OFS_KEY_STATUS: next_rdata = {2'h0, row_write_key_flag,
                    programming_key_flag, erase_key_flag, 3'h0};
                OFS_RESET_REQ: next_rdata = reset_req;
                OFS_CLK_SEL: next_rdata = {6'h00, clk_sel};
                OFS_SYS_CTRL: next_rdata = {6'h00, state == ST_ROW_COPY, hold};
                OFS_SYS_STATE: next_rdata = {2'h0, system_reset_active, sys_sleeping, // R20
                    state == ST_PROGRAMMING, row_program_ready, 1'b0,
                    lock_state_flag}; // R1
                OFS_BOOT_CHECK: next_rdata = {5'h00, boot_crc};
                default: next_rdata = 8'h00;
            endcase
            if (reg_addr == OFS_ERROR) begin
                next_err = 3'h0;
            end
        end
        // register port stays live whatever the system sleep state
        if (reg_wr) begin // R16
            unique case (reg_addr)
                OFS_CTRL_A: next_ctrl_a = reg_wdata;
                OFS_CTRL_B: next_ctrl_b = reg_wdata;
                OFS_CLK_SEL: next_clk_sel = reg_wdata[1:0];
                OFS_SYS_CTRL: begin
                    next_hold = reg_wdata[SC_HOLD];
                    if (reg_wdata[SC_FINISH] && state == ST_ROW_READY) begin
                        next_state = ST_ROW_COPY; // R10
                        next_idx = 6'h00;
                    end
                end
                OFS_KEY_STATUS: begin
                    if (reg_wdata[KS_ROW]) begin
                        next_row_key = 1'b0; // R11
                        if (row_mode) begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                OFS_RESET_REQ: begin
                    // only the system is reset; this block keeps its state
                    next_reset_req = reg_wdata; // R21
                    if (reg_wdata == RESET_CODE && !system_reset_active) begin
                        next_sys_reset = 1'b1; // R5
                        next_erase_key = 1'b0;
                        if (erase_key_flag) begin
                            next_state = ST_ERASE_ARMED;
                        end else if (state == ST_PROGRAMMING) begin
                            next_state = ST_IDLE; // R7
                        end else if (programming_key_flag && !lock_state_flag) begin
                            next_state = ST_PROG_ARMED; // R6
                        end else if (row_write_key_flag && lock_state_flag) begin
                            next_state = ST_ROW_ARMED; // R8
                        end
                    end else if (reg_wdata == RUN_CODE && system_reset_active) begin
                        next_sys_reset = 1'b0; // R5
                        next_lock = lock_fuse;
                        unique case (state)
                            ST_ERASE_ARMED: begin
                                next_state = ST_ERASING;
                                next_erase_start = 1'b1;
                            end
                            ST_PROG_ARMED: begin
                                next_state = ST_PROGRAMMING;
                                next_prog_key = 1'b0; // R22
                            end
                            ST_ROW_ARMED: next_state = ST_ROW_READY;
                            default: next_state = state;
                        endcase
                    end
                end
                default: next_state = next_state;
            endcase
        end
        if (state == ST_ERASING && erase_done) begin
            next_lock = 1'b0; // R2
            next_state = ST_IDLE;
        end
        // copy buffer to row: read at idx, byte emerges one cycle later
        if (state == ST_ROW_COPY) begin
            next_idx = idx + 6'h01;
            if (idx != 6'h00) begin
                next_row_out = '{valid: 1'b1, addr: 5'(idx - 6'h01), data: buf_rdata};
            end
            if (idx == COPY_END) begin
                next_state = ST_ROW_DONE;
                next_row_out = '0;
            end
        end
        // memory access from the link
        if (link_req.valid && enabled) begin
            if (row_mode) begin
                if (!link_req.write) begin
                    next_link_rsp = '{valid: 1'b1, data: 8'h00}; // R12
                end
            end else if (!lock_state_flag && sys_clock_on) begin // R3 R17
                next_sys_req = link_req;
            end else begin
                next_err = ERR_BUS;
            end
        end
        if (!row_mode && sys_rsp.valid) begin
            next_link_rsp = sys_rsp;
        end
        // key set wins over a clear in the same cycle, except the disable clear below
        if (match.erase) begin
            next_erase_key = 1'b1;
        end
        if (match.prog) begin
            next_prog_key = 1'b1;
        end
        if (match.row) begin
            next_row_key = 1'b1;
        end
        if (phy_err_valid) begin
            next_err = phy_err_code;
        end
        // disabling drops keys; hold returns to 1 ready for re-enable
        if (!next_ctrl_b[CB_DISABLE] == 1'b0) begin
            next_erase_key = 1'b0;
            next_prog_key = 1'b0;
            next_row_key = 1'b0;
            next_hold = 1'b1; // R19
            if (state != ST_ERASING) begin
                next_state = ST_IDLE;
            end
        end
        next_bod = (next_state == ST_ERASING); // R4
        next_hold_out = next_hold && !next_ctrl_b[CB_DISABLE]; // R18
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ST_IDLE;
            err <= 3'h0;
            ctrl_a <= CTRL_RESET;
            ctrl_b <= CTRL_RESET;
            reset_req <= RUN_CODE;
            clk_sel <= CLK_SEL_RESET;
            hold <= 1'b1;
            lock_state_flag <= 1'b1;
            lock_loaded <= 1'b0;
            erase_key_flag <= 1'b0;
            programming_key_flag <= 1'b0;
            row_write_key_flag <= 1'b0;
            idx <= 6'h00;
            system_reset_active <= 1'b0;
            erase_start <= 1'b0;
            brownout_force <= 1'b0;
            system_clock_hold <= 1'b0;
            sys_req <= '0;
            link_rsp <= '0;
            row_out <= '0;
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            state <= next_state;
            err <= next_err;
            ctrl_a <= next_ctrl_a;
            ctrl_b <= next_ctrl_b;
            reset_req <= next_reset_req;
            clk_sel <= next_clk_sel;
            hold <= next_hold;
            lock_state_flag <= next_lock;
            lock_loaded <= 1'b1;
            erase_key_flag <= next_erase_key;
            programming_key_flag <= next_prog_key;
            row_write_key_flag <= next_row_key;
            idx <= next_idx;
            system_reset_active <= next_sys_reset;
            erase_start <= next_erase_start;
            brownout_force <= next_bod;
            system_clock_hold <= next_hold_out;
            sys_req <= next_sys_req;
            link_rsp <= next_link_rsp;
            row_out <= next_row_out;
            reg_rdata <= next_rdata;
            reg_rvalid <= reg_rd;
        end
    end

    // output only, no event inputs exist on this block
    always_ff @(posedge clk) begin // R15
        if (reset) begin
            sync_q1 <= 1'b0;
            sync_q2 <= 1'b0;
            sync_q3 <= 1'b0;
            sync_event <= 1'b0;
        end else begin
            sync_q1 <= sync_pin;
            sync_q2 <= sync_q1;
            sync_q3 <= sync_q2;
            sync_event <= sync_q2 && !sync_q3; // R14
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_reset_code;
        reg_wr && reg_addr == OFS_RESET_REQ && reg_wdata == RESET_CODE;
    endsequence
    sequence s_release_code;
        reg_wr && reg_addr == OFS_RESET_REQ && reg_wdata == RUN_CODE;
    endsequence
    sequence s_row_read;
        enabled && row_mode && link_req.valid && !link_req.write;
    endsequence

    a_reset_assert: assert property (s_reset_code |=> system_reset_active) // R5
        else $error("reset code did not assert system reset");
    a_reset_release: assert property (s_release_code |=> !system_reset_active) // R5
        else $error("release code did not clear system reset");
    a_locked_refuse: assert property (lock_state_flag && !row_mode |=> !sys_req.valid) // R3
        else $error("system bus reached while locked");
    a_erase_unlock: assert property (state == ST_ERASING && erase_done |=> // R2
        !lock_state_flag && state == ST_IDLE)
        else $error("erase completion left device locked");
    a_bod_erase: assert property ($rose(state == ST_ERASING) |-> brownout_force) // R4
        else $error("brownout not forced during erase");
    a_row_blank_read: assert property (s_row_read |=> link_rsp.valid && link_rsp.data == 8'h00) // R12
        else $error("row mode read returned data");
    a_row_no_bus: assert property (row_mode |=> !sys_req.valid) // R9
        else $error("row mode access reached system bus");
    a_copy_length: assert property ($rose(state == ST_ROW_COPY) |-> // R10
        row_program_ready [*8] ##27 (state == ST_ROW_DONE && !row_program_ready))
        else $error("row copy did not end after 34 cycles");
    a_sync_edge: assert property (sync_q2 && !sync_q3 |=> sync_event ##1 !sync_event) // R14
        else $error("sync edge missed");
    a_hold_enable: assert property ($rose(enabled) |-> hold ##1 system_clock_hold) // R19
        else $error("clock hold not set on enable");
    a_clock_gate: assert property (!sys_clock_on |=> !sys_req.valid) // R17
        else $error("bus access without system clock");
    a_prog_key_clear: assert property ((state == ST_PROG_ARMED) ##0 s_release_code // R22
        |=> state == ST_PROGRAMMING && !programming_key_flag)
        else $error("programming key not cleared on start");
endmodule
`default_nettype wire

// File: test/programmer_model.sv
`timescale 1ns/1ps
`default_nettype none
module programmer_model import dbg_access_pkg::*; (
    // clock
    input wire logic clk,
    // register port toward the block
    output logic reg_wr,
    output logic reg_rd,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // key bytes
    output logic key_valid,
    output logic [7:0] key_byte
);
    initial begin
        {reg_wr, reg_rd, key_valid} = 3'h0;
        reg_addr = 4'hF;
        reg_wdata = 8'h00;
        key_byte = 8'h00;
    end
    // released data lines flip so a stale value never looks valid
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) #2;
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge clk) #2;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk) #2;
        {reg_rd, reg_addr} = {1'b1, a};
        @(posedge clk) #2;
        reg_rd = 1'b0;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    endtask
    task automatic send_key(input logic [63:0] k);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) #2;
            {key_valid, key_byte} = {1'b1, k[8*i +: 8]};
        end
        @(posedge clk) #2;
        key_valid = 1'b0;
        key_byte = ~key_byte;
    endtask
    task automatic reset_cycle();
        wr(OFS_RESET_REQ, RESET_CODE);
        wr(OFS_RESET_REQ, RUN_CODE);
    endtask
    // bounded status poll; gives up rather than hang
    task automatic poll(input int b, input logic v, output logic ok);
        logic [7:0] d;
        ok = 1'b0;
        for (int i = 0; i < 64 && !ok; i++) begin
            rd(OFS_SYS_STATE, d);
            ok = (d[b] === v);
        end
    endtask
endmodule
`default_nettype wire

// File: test/debug_access_key_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module debug_access_key_sequencer_tb import dbg_access_pkg::*;;
    logic clk = 0, reset = 1, reg_wr, reg_rd, reg_rvalid, key_valid, sync_pin = 0;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, key_byte, rsp_data, d;
    logic phy_err_valid = 0, sys_clock_on = 1, sys_sleeping = 1, lock_fuse = 1;
    logic erase_done = 0, system_reset_active, erase_start, brownout_force;
    logic system_clock_hold, sync_event, ok;
    logic [2:0] phy_err_code = 3'h0, boot_crc = 3'h5;
    bus_req_t link_req = '0, sys_req;
    rsp_t link_rsp, sys_rsp = '0;
    row_wr_t row_out;
    int err_total, checked, n_fwd, n_row, n_sync, n_erase;

    debug_access_key_sequencer dut (.clk, .reset, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_rvalid, .key_valid, .key_byte, .phy_err_valid,
        .phy_err_code, .sync_pin, .link_req, .link_rsp, .sys_req, .sys_rsp,
        .sys_clock_on, .sys_sleeping, .lock_fuse, .erase_done, .boot_crc,
        .system_reset_active, .erase_start, .brownout_force, .system_clock_hold,
        .row_out, .sync_event);
    programmer_model pm (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid, .key_valid, .key_byte);

    always #12.5 clk = ~clk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic lreq(input logic w, input logic [15:0] a, input logic [7:0] v);
        @(posedge clk) #2;
        link_req = '{1'b1, w, a, v};
        @(posedge clk) #2;
        link_req.valid = 1'b0;
        link_req.wdata = ~v;
    endtask

    // mid-cycle sampling avoids racing the design's edge; system answers next cycle
    always @(negedge clk) begin
        sys_rsp <= '{(sys_req.valid === 1'b1) && !sys_req.write, 8'h3C};
        if (sys_req.valid === 1'b1) n_fwd++;
        if (link_rsp.valid === 1'b1) rsp_data = link_rsp.data;
        if (sync_event === 1'b1) n_sync++;
        if (erase_start === 1'b1) n_erase++;
        if (row_out.valid === 1'b1) begin
            chk({3'h0, row_out.addr}, n_row[7:0]);
            chk(row_out.data, {3'h5, row_out.addr});
            n_row++;
        end
    end

    task automatic t_regs();
        logic [3:0] a [9] = '{OFS_REVISION, OFS_ERROR, OFS_CTRL_A, OFS_KEY_STATUS,
            OFS_RESET_REQ, OFS_CLK_SEL, OFS_SYS_CTRL, OFS_BOOT_CHECK, 4'h5};
        logic [7:0] e [9] = '{{REV_RESET, 4'h0}, 8'h00, CTRL_RESET, 8'h00, 8'h00,
            {6'h0, CLK_SEL_RESET}, 8'h01, 8'h05, 8'h00};
        pm.wr(OFS_REVISION, 8'hFF);
        pm.wr(4'h5, 8'hFF);
        for (int i = 0; i < 9; i++) begin
            pm.rd(a[i], d);
            chk(d, e[i]);
        end
        pm.rd(OFS_SYS_STATE, d);
        chk(d, 8'h11);
        sys_sleeping = 1'b0;
        pm.rd(OFS_SYS_STATE, d);
        chk(d, 8'h01);
        sys_sleeping = 1'b1;
        chk(system_clock_hold, 8'h01);
        $display("registers test done");
    endtask
    task automatic t_erase();
        lreq(1'b0, 16'h0100, 8'h00);
        repeat (3) @(posedge clk);
        chk(n_fwd[7:0], 8'h00);
        pm.rd(OFS_ERROR, d);
        chk(d, {5'h0, ERR_BUS});
        pm.send_key(64'h0123456789ABCDEF);
        pm.rd(OFS_KEY_STATUS, d);
        chk(d, 8'h00);
        pm.send_key(KEY_ERASE);
        pm.rd(OFS_KEY_STATUS, d);
        chk(d, 8'h08);
        pm.wr(OFS_RESET_REQ, RESET_CODE);
        pm.rd(OFS_SYS_STATE, d);
        chk(d, 8'h31);
        pm.wr(OFS_RESET_REQ, RUN_CODE);
        repeat (4) @(posedge clk);
        #2;
        chk(n_erase[7:0], 8'h01);
        chk(brownout_force, 8'h01);
        chk(system_reset_active, 8'h00);
        lock_fuse = 1'b0;
        erase_done = 1'b1;
        @(posedge clk) #2;
        erase_done = 1'b0;
        pm.poll(SS_LOCK, 1'b0, ok);
        chk(ok, 8'h01);
        chk(brownout_force, 8'h00);
        lreq(1'b0, 16'h0100, 8'h00);
        repeat (3) @(posedge clk);
        chk(n_fwd[7:0], 8'h01);
        chk(rsp_data, 8'h3C);
        sys_clock_on = 1'b0;
        lreq(1'b0, 16'h0100, 8'h00);
        repeat (3) @(posedge clk);
        chk(n_fwd[7:0], 8'h01);
        sys_clock_on = 1'b1;
        $display("erase test done");
    endtask
    task automatic t_prog();
        pm.send_key(KEY_PROG);
        pm.rd(OFS_KEY_STATUS, d);
        chk(d, 8'h10);
        pm.reset_cycle();
        pm.poll(SS_PROG, 1'b1, ok);
        chk(ok, 8'h01);
        pm.rd(OFS_KEY_STATUS, d);
        chk(d, 8'h00);
        pm.reset_cycle();
        pm.wr(OFS_SYS_CTRL, 8'h00);
        @(posedge clk) #2;
        chk(system_clock_hold, 8'h00);
        pm.wr(OFS_CTRL_B, 8'h04);
        pm.wr(OFS_CTRL_B, 8'h00);
        pm.rd(OFS_SYS_CTRL, d);
        chk(d, 8'h01);
        chk(system_clock_hold, 8'h01);
        $display("programming test done");
    endtask
    task automatic t_row();
        lock_fuse = 1'b1;
        pm.reset_cycle();
        pm.send_key(KEY_ROW);
        pm.reset_cycle();
        pm.poll(SS_ROW_READY, 1'b1, ok);
        chk(ok, 8'h01);
        // slot 32 must be dropped, not wrapped onto slot 0
        for (int i = 0; i <= ROW_BYTES; i++)
            lreq(1'b1, 16'(i), (i < ROW_BYTES) ? {3'h5, 5'(i)} : 8'hEE);
        lreq(1'b0, 16'h0003, 8'h00);
        repeat (2) @(posedge clk);
        chk(rsp_data, 8'h00);
        pm.wr(OFS_SYS_CTRL, 8'h03);
        pm.poll(SS_ROW_READY, 1'b0, ok);
        chk(ok, 8'h01);
        chk(n_row[7:0], 8'(ROW_BYTES));
        pm.wr(OFS_KEY_STATUS, 8'h20);
        pm.rd(OFS_KEY_STATUS, d);
        chk(d, 8'h00);
        pm.reset_cycle();
        $display("row test done");
    endtask
    task automatic t_sync();
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) #2 sync_pin = 1'b1;
            repeat (3) @(posedge clk);
            #2 sync_pin = 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (5) @(posedge clk);
        chk(n_sync[7:0], 8'h03);
        $display("sync test done");
    endtask

    task automatic print_verdict();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        #2 reset = 1'b0;
        repeat (2) @(posedge clk);
        t_regs();
        t_erase();
        t_prog();
        t_row();
        t_sync();
        print_verdict();
    end
    // whole run needs a few hundred cycles
    initial begin
        #(25 * 20000);
        err_total++;
        print_verdict();
    end
endmodule
`default_nettype wire
